//--- rtl/lbx_map.vh
/*
 constants for the logic/branch/swap execute unit: opcode fields, flag bit
 positions, condition codes and reset values. assumes plain Verilog-2005.
*/
`ifndef LBX_MAP_VH
`define LBX_MAP_VH
// flag bit positions inside the program status word
`define LBX_FLAG_Z 0
`define LBX_FLAG_S 1
`define LBX_FLAG_OV 2
`define LBX_FLAG_CY 3
`define LBX_FLAG_SAT 4
// first-halfword opcode fields
`define LBX_OPC_AND 6'h0A
`define LBX_OPC_BITWISE_AND_IMM_OP 6'h36
`define LBX_OPC_ADD_IMMEDIATE_OP 6'h30
`define LBX_OPC_BCOND 4'hB
`define LBX_OPC_TABLE_LOOKUP_CALL_OP 10'h008
`define LBX_OPC_EXT 6'h3F
`define LBX_OPC_CLR1D 6'h3E
// second-halfword codes
`define LBX_SUB_BSH 11'h342
`define LBX_SUB_BSW 11'h340
`define LBX_SUB_CONDITIONAL_MOVE_OP 6'h19
`define LBX_SUB_CMOVI 6'h18
`define LBX_SUB_CLR1R 16'h00E4
// condition codes
`define LBX_CC_V 4'h0
`define LBX_CC_C 4'h1
`define LBX_CC_Z 4'h2
`define LBX_CC_NH 4'h3
`define LBX_CC_N 4'h4
`define LBX_CC_T 4'h5
`define LBX_CC_LT 4'h6
`define LBX_CC_LE 4'h7
`define LBX_CC_NV 4'h8
`define LBX_CC_NC 4'h9
`define LBX_CC_NZ 4'hA
`define LBX_CC_H 4'hB
`define LBX_CC_P 4'hC
`define LBX_CC_SA 4'hD
`define LBX_CC_GE 4'hE
`define LBX_CC_GT 4'hF
// reset values and sequential step
`define LBX_RST_WORD 32'h00000000
`define LBX_RST_FLAGS 5'h00
`define LBX_PC_STEP2 32'h00000002
`define LBX_PC_STEP4 32'h00000004
`endif

//--- rtl/lbx_exec_unit.v
/*
 execute stage for a group of instructions: add immediate, and, and immediate,
 conditional branch, byte swaps, table-lookup call, memory bit clear and
 conditional move. assumes the register file answers reads combinationally on
 the same clock, and data memory answers a read one cycle after mem_rd_o.
*/
// The plain strobed port and the register offsets are this design's own decisions.
// Function
// - add immediate: sign-extend 16-bit immediate, add to first source, write destination
// - register and: destination AND source back to destination, opcode 001010
// - and immediate zero-extends immediate, clears overflow, sets zero on zero result
// - and and swaps clear overflow, sign follows result bit 31
// - register and sets zero on zero result, keeps carry and saturation
// - conditional branch tests selected flags, branches or falls through, no flag change
// - branch displacement bit 0 forced zero, nine bits sign-extended
// - branch target is branch address plus displacement
// - signed codes 1110, 0110, 1111, 0111 use sign xor overflow and zero
// - unsigned codes 1011, 0011, 0001, 1001 use carry and zero
// - other codes test zero, sign, overflow, saturation or always
// - halfword swap byte order; carry when a lower result byte is zero
// - halfword swap zero flag from lower result halfword only
// - word swap reverses bytes; carry on any zero byte, zero on zero word
// - table call saves next address and status word first
// - table entry address is base plus immediate shifted left one
// - table call target is base plus loaded halfword, no flag change
// - table call may pause after memory cycle for interrupt, then resumes
// - bit clear reads byte, clears bit, writes back; two address forms
// - bit clear zero flag is inverse of old bit, other flags kept
// - conditional move picks first source or second register by condition
// - immediate conditional move writes sign-extended 5-bit immediate when taken
// - flags not named by an instruction keep their previous value
`timescale 1ns/1ps
`include "lbx_map.vh"
module lbx_exec_unit
(
	input wire mclk_i,
	input wire rst_i,
	input wire start_i,
	input wire [31:0] instr_i,
	input wire [31:0] pc_i,
	input wire [31:0] rs1_data_i,
	input wire [31:0] rs2_data_i,
	input wire [31:0] call_table_base_i,
	input wire [4:0] psw_flags_i,
	input wire [31:0] psw_word_i,
	input wire [15:0] mem_rdata_i,
	input wire irq_pending_i,
	output reg [4:0] rs1_addr_o,
	output reg [4:0] rs2_addr_o,
	output reg busy_o,
	output reg done_o,
	output reg illegal_o,
	output reg rd_we_o,
	output reg [4:0] rd_addr_o,
	output reg [31:0] rd_data_o,
	output reg flags_we_o,
	output reg [4:0] flags_o,
	output reg pc_we_o,
	output reg [31:0] pc_o,
	output reg ct_save_we_o,
	output reg [31:0] call_return_pc_save_o,
	output reg [31:0] call_return_status_save_o,
	output reg mem_rd_o,
	output reg mem_wr_o,
	output reg mem_half_o,
	output reg [31:0] mem_addr_o,
	output reg [7:0] mem_wdata_o,
	output reg suspended_o
);

// one-hot states; both memory ops pass through the read wait before use
localparam ST_IDLE = 6'h01;
localparam ST_EXEC = 6'h02;
localparam ST_RDWAIT = 6'h04;
localparam ST_FINISH = 6'h08;
localparam ST_HOLD = 6'h10;
localparam ST_MEMWAIT = 6'h20;

reg [5:0] state_reg;
reg [31:0] instr_reg;
reg [31:0] pc_reg;
reg [31:0] addr_reg;
reg [2:0] bitno_reg;
reg is_call_reg;

wire [5:0] opc = instr_reg[10:5];
wire [4:0] f_r1 = instr_reg[4:0];
wire [4:0] f_r2 = instr_reg[15:11];
wire [4:0] f_r3 = instr_reg[31:27];
wire [15:0] imm16 = instr_reg[31:16];
wire is_and = (opc == `LBX_OPC_AND);
wire is_bitwise_and_imm_op = (opc == `LBX_OPC_BITWISE_AND_IMM_OP);
wire is_add_immediate_op = (opc == `LBX_OPC_ADD_IMMEDIATE_OP);
wire is_bcond = (instr_reg[10:7] == `LBX_OPC_BCOND);
wire is_table_lookup_call_op = (instr_reg[15:6] == `LBX_OPC_TABLE_LOOKUP_CALL_OP);
wire is_ext = (opc == `LBX_OPC_EXT);
wire is_bsh = is_ext && (instr_reg[26:16] == `LBX_SUB_BSH);
wire is_bsw = is_ext && (instr_reg[26:16] == `LBX_SUB_BSW);
wire is_conditional_move_op = is_ext && (instr_reg[26:21] == `LBX_SUB_CONDITIONAL_MOVE_OP) && !instr_reg[16];
wire is_cmovi = is_ext && (instr_reg[26:21] == `LBX_SUB_CMOVI) && !instr_reg[16];
wire is_clrd = (opc == `LBX_OPC_CLR1D) && (instr_reg[15:14] == 2'b10);
wire is_clrr = is_ext && (instr_reg[31:16] == `LBX_SUB_CLR1R);

wire fz = psw_flags_i[`LBX_FLAG_Z];
wire fs = psw_flags_i[`LBX_FLAG_S];
wire fov = psw_flags_i[`LBX_FLAG_OV];
wire fcy = psw_flags_i[`LBX_FLAG_CY];
wire fsat = psw_flags_i[`LBX_FLAG_SAT];

function cond_ok;
	input [3:0] cc;
	input z, s, ov, cy, saturation_flag;
	begin
		case (cc)
			`LBX_CC_GE: cond_ok = ((s ^ ov) == 1'b0);
			`LBX_CC_LT: cond_ok = ((s ^ ov) == 1'b1);
			`LBX_CC_GT: cond_ok = (((s ^ ov) | z) == 1'b0);
			`LBX_CC_LE: cond_ok = (((s ^ ov) | z) == 1'b1);
			`LBX_CC_H: cond_ok = ((cy | z) == 1'b0);
			`LBX_CC_NH: cond_ok = ((cy | z) == 1'b1);
			`LBX_CC_C: cond_ok = cy;
			`LBX_CC_NC: cond_ok = !cy;
			`LBX_CC_Z: cond_ok = z;
			`LBX_CC_NZ: cond_ok = !z;
			`LBX_CC_N: cond_ok = s;
			`LBX_CC_P: cond_ok = !s;
			`LBX_CC_V: cond_ok = ov;
			`LBX_CC_NV: cond_ok = !ov;
			`LBX_CC_SA: cond_ok = saturation_flag;
			`LBX_CC_T: cond_ok = 1'b1;
			default: cond_ok = 1'b0;
		endcase
	end
endfunction

// register file ports follow the latched instruction; for swaps the source
// sits in the second-register field, for register-form bit clear it gives the bit number
always @*
begin
	rs1_addr_o = f_r1;
	rs2_addr_o = f_r2;
end

wire [31:0] and_res = rs2_data_i & rs1_data_i;
wire [31:0] bitwise_and_imm_op_res = rs1_data_i & {16'h0000, imm16};
// a 33-bit sum keeps the carry out of bit 31 for the flag write
wire [32:0] add_immediate_op_sum = {1'b0, rs1_data_i} + {1'b0, {16{imm16[15]}}, imm16};
wire [31:0] add_immediate_op_res = add_immediate_op_sum[31:0];
wire add_immediate_op_cy = add_immediate_op_sum[32];
// overflow only when both operands share a sign that the sum does not
wire add_immediate_op_ov = (rs1_data_i[31] == imm16[15]) && (add_immediate_op_res[31] != rs1_data_i[31]);
wire add_immediate_op_z = (add_immediate_op_res == 32'h00000000);
wire [31:0] bsh_res = {rs2_data_i[23:16], rs2_data_i[31:24],
	rs2_data_i[7:0], rs2_data_i[15:8]};
wire [31:0] bsw_res = {rs2_data_i[7:0], rs2_data_i[15:8],
	rs2_data_i[23:16], rs2_data_i[31:24]};
wire [31:0] bdisp = {{23{instr_reg[15]}}, instr_reg[15:11], instr_reg[6:4], 1'b0};
wire [31:0] btarget = pc_reg + bdisp;
wire bc_ok = cond_ok(instr_reg[3:0], fz, fs, fov, fcy, fsat);
wire cm_ok = cond_ok(instr_reg[20:17], fz, fs, fov, fcy, fsat);
wire [31:0] cmi_val = {{27{instr_reg[4]}}, instr_reg[4:0]};
wire [31:0] ct_addr = call_table_base_i + {25'h0000000, instr_reg[5:0], 1'b0};
wire [7:0] old_byte = addr_reg[0] ? mem_rdata_i[15:8] : mem_rdata_i[7:0];
wire old_bit = old_byte[bitno_reg];

function [4:0] mk_flags;
	input z, s, ov, cy, saturation_flag;
	begin
		mk_flags = 5'h00;
		mk_flags[`LBX_FLAG_Z] = z;
		mk_flags[`LBX_FLAG_S] = s;
		mk_flags[`LBX_FLAG_OV] = ov;
		mk_flags[`LBX_FLAG_CY] = cy;
		mk_flags[`LBX_FLAG_SAT] = saturation_flag;
	end
endfunction

always @(posedge mclk_i)
begin
	if (rst_i)
	begin
		state_reg <= ST_IDLE;
		instr_reg <= `LBX_RST_WORD;
		pc_reg <= `LBX_RST_WORD;
		addr_reg <= `LBX_RST_WORD;
		bitno_reg <= 3'h0;
		is_call_reg <= 1'b0;
		busy_o <= 1'b0;
		done_o <= 1'b0;
		illegal_o <= 1'b0;
		rd_we_o <= 1'b0;
		rd_addr_o <= 5'h00;
		rd_data_o <= `LBX_RST_WORD;
		flags_we_o <= 1'b0;
		flags_o <= `LBX_RST_FLAGS;
		pc_we_o <= 1'b0;
		pc_o <= `LBX_RST_WORD;
		ct_save_we_o <= 1'b0;
		call_return_pc_save_o <= `LBX_RST_WORD;
		call_return_status_save_o <= `LBX_RST_WORD;
		mem_rd_o <= 1'b0;
		mem_wr_o <= 1'b0;
		mem_half_o <= 1'b0;
		mem_addr_o <= `LBX_RST_WORD;
		mem_wdata_o <= 8'h00;
		suspended_o <= 1'b0;
	end
	else
	begin
		done_o <= 1'b0;
		illegal_o <= 1'b0;
		rd_we_o <= 1'b0;
		flags_we_o <= 1'b0;
		pc_we_o <= 1'b0;
		ct_save_we_o <= 1'b0;
		mem_rd_o <= 1'b0;
		mem_wr_o <= 1'b0;
		case (state_reg)
			ST_IDLE:
			begin
				if (start_i)
				begin
					instr_reg <= instr_i;
					pc_reg <= pc_i;
					busy_o <= 1'b1;
					state_reg <= ST_EXEC;
				end
			end
			ST_EXEC:
			begin
				// flags not listed here are written back unchanged
				flags_o <= psw_flags_i;
				rd_addr_o <= f_r2;
				state_reg <= ST_FINISH;
				if (is_and)
				begin
					rd_we_o <= 1'b1;
					rd_data_o <= and_res;
					flags_we_o <= 1'b1;
					flags_o <= mk_flags(and_res == 32'h00000000, and_res[31], 1'b0,
						fcy, fsat);
				end
				else if (is_bitwise_and_imm_op)
				begin
					rd_we_o <= 1'b1;
					rd_data_o <= bitwise_and_imm_op_res;
					flags_we_o <= 1'b1;
					flags_o <= mk_flags(bitwise_and_imm_op_res == 32'h00000000, fs, 1'b0,
						fcy, fsat);
				end
				else if (is_add_immediate_op)
				begin
					rd_we_o <= 1'b1;
					rd_data_o <= add_immediate_op_res;
					flags_we_o <= 1'b1;
					flags_o <= mk_flags(add_immediate_op_z, add_immediate_op_res[31], add_immediate_op_ov, add_immediate_op_cy,
						fsat);
				end
				else if (is_bcond)
				begin
					// no flag write for branches
					pc_we_o <= 1'b1;
					pc_o <= bc_ok ? btarget : (pc_reg + `LBX_PC_STEP2);
				end
				else if (is_bsh || is_bsw)
				begin
					rd_we_o <= 1'b1;
					rd_addr_o <= f_r3;
					rd_data_o <= is_bsh ? bsh_res : bsw_res;
					flags_we_o <= 1'b1;
					if (is_bsh)
						flags_o <= mk_flags(bsh_res[15:0] == 16'h0000, bsh_res[31], 1'b0,
							(bsh_res[7:0] == 8'h00) || (bsh_res[15:8] == 8'h00),
							fsat);
					else
						flags_o <= mk_flags(bsw_res == 32'h00000000, bsw_res[31], 1'b0,
							(bsw_res[7:0] == 8'h00) || (bsw_res[15:8] == 8'h00) ||
							(bsw_res[23:16] == 8'h00) || (bsw_res[31:24] == 8'h00),
							fsat);
				end
				else if (is_conditional_move_op || is_cmovi)
				begin
					rd_we_o <= 1'b1;
					rd_addr_o <= f_r3;
					if (cm_ok)
						rd_data_o <= is_conditional_move_op ? rs1_data_i : cmi_val;
					else
						rd_data_o <= rs2_data_i;
				end
				else if (is_table_lookup_call_op)
				begin
					// save goes out in the same cycle as the table read strobe
					ct_save_we_o <= 1'b1;
					call_return_pc_save_o <= pc_reg + `LBX_PC_STEP2;
					call_return_status_save_o <= psw_word_i;
					mem_rd_o <= 1'b1;
					mem_half_o <= 1'b1;
					mem_addr_o <= ct_addr;
					is_call_reg <= 1'b1;
					state_reg <= ST_MEMWAIT;
				end
				else if (is_clrd || is_clrr)
				begin
					addr_reg <= is_clrd ? (rs1_data_i + {{16{imm16[15]}}, imm16})
						: rs1_data_i;
					bitno_reg <= is_clrd ? instr_reg[13:11] : rs2_data_i[2:0];
					mem_rd_o <= 1'b1;
					mem_half_o <= 1'b0;
					mem_addr_o <= is_clrd ? (rs1_data_i + {{16{imm16[15]}}, imm16})
						: rs1_data_i;
					is_call_reg <= 1'b0;
					state_reg <= ST_MEMWAIT;
				end
				else
				begin
					// unknown codes write nothing and only report themselves
					illegal_o <= 1'b1;
				end
			end
			ST_MEMWAIT:
			begin
				// read data stand only in the cycle after the strobe, so one
				// edge passes before the memory answer is used
				state_reg <= ST_RDWAIT;
			end
			ST_RDWAIT:
			begin
				if (is_call_reg)
				begin
					pc_we_o <= 1'b1;
					pc_o <= call_table_base_i + {16'h0000, mem_rdata_i};
				end
				else
				begin
					mem_wr_o <= 1'b1;
					mem_wdata_o <= old_byte & ~(8'h01 << bitno_reg);
					flags_we_o <= 1'b1;
					flags_o <= mk_flags(!old_bit, fs, fov, fcy, fsat);
				end
				// an interrupt may park the unit once the memory cycle is done
				if (irq_pending_i)
				begin
					suspended_o <= 1'b1;
					state_reg <= ST_HOLD;
				end
				else
					state_reg <= ST_FINISH;
			end
			ST_HOLD:
			begin
				// the write-back or jump has already gone out; only done waits here
				if (!irq_pending_i)
				begin
					suspended_o <= 1'b0;
					state_reg <= ST_FINISH;
				end
			end
			ST_FINISH:
			begin
				done_o <= 1'b1;
				busy_o <= 1'b0;
				state_reg <= ST_IDLE;
			end
			default:
				state_reg <= ST_IDLE;
		endcase
	end
end

endmodule

//--- verification/lbx_exec_assertions.sv
/*
 checker for the execute unit, bound to its top ports.
 assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module lbx_exec_checker
(
	input wire mclk_i,
	input wire rst_i,
	input wire start_i,
	input wire [31:0] instr_i,
	input wire irq_pending_i,
	input wire busy_o,
	input wire done_o,
	input wire rd_we_o,
	input wire flags_we_o,
	input wire pc_we_o,
	input wire ct_save_we_o,
	input wire mem_rd_o,
	input wire mem_wr_o,
	input wire mem_half_o,
	input wire suspended_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	wire take = start_i && !busy_o;
	branch_flags_a: assert property (take && instr_i[10:7] == 4'hB |=> !flags_we_o [*3])
		else $error("branch wrote flags");
	conditional_move_op_flags_a: assert property (take && instr_i[10:5] == 6'h3F && instr_i[26:22] == 5'h0C
		|=> !flags_we_o [*3])
		else $error("conditional move wrote flags");
	call_flags_a: assert property (take && instr_i[15:6] == 10'h008 |=> !flags_we_o [*4])
		else $error("table call wrote flags");
	call_save_a: assert property (ct_save_we_o |-> mem_rd_o && mem_half_o)
		else $error("save without table read");
	call_jump_a: assert property (ct_save_we_o |-> ##2 pc_we_o)
		else $error("table call did not jump");
	clr_write_a: assert property (mem_rd_o && !mem_half_o |-> ##2 mem_wr_o)
		else $error("bit clear did not write back");
	resume_a: assert property (suspended_o && !irq_pending_i |-> ##[1:3] done_o)
		else $error("no resume after interrupt");
	and_write_a: assert property (take && instr_i[10:5] == 6'h0A
		|=> ##1 rd_we_o && flags_we_o)
		else $error("and result or flags missing");
	done_pulse_a: assert property (done_o |=> !done_o)
		else $error("done longer than one cycle");
endmodule
bind lbx_exec_unit lbx_exec_checker lbx_exec_checker_i (.mclk_i, .rst_i, .start_i, .instr_i,
	.irq_pending_i, .busy_o, .done_o, .rd_we_o, .flags_we_o, .pc_we_o, .ct_save_we_o,
	.mem_rd_o, .mem_wr_o, .mem_half_o, .suspended_o);

//--- verification/lbx_mem_model.sv
/*
 16-byte data memory; halfword read data the cycle after the read strobe.
 assumes only address bits 3:0 matter.
*/
`timescale 1ns/1ps
module lbx_mem_model
(
	input wire mclk_i,
	input wire mem_rd_i,
	input wire mem_wr_i,
	input wire [31:0] mem_addr_i,
	input wire [7:0] mem_wdata_i,
	output logic [15:0] mem_rdata_o
);
	logic [7:0] m [0:15];
	wire [3:0] ha = {mem_addr_i[3:1], 1'b0};
	initial
	begin
		mem_rdata_o = 16'h0000;
		for (int k = 0; k < 16; k++) m[k] = 8'(8'h11 * k);
	end
	// lines toggle outside a read answer so stale data never looks valid
	always @(posedge mclk_i)
	begin
		mem_rdata_o <= mem_rd_i ? {m[ha | 4'h1], m[ha]} : ~mem_rdata_o;
		if (mem_wr_i) m[mem_addr_i[3:0]] <= mem_wdata_i;
	end
endmodule

//--- verification/lbx_exec_unit_tb.sv
/*
 self-checking bench for the execute unit.
 assumes the memory model beside it and a fixed call table base.
*/
`timescale 1ns/1ps
module lbx_exec_unit_tb;
	logic mclk_i = 0, rst_i = 1, start_i = 0, irq = 0;
	logic [31:0] ins = 0, pc = 32'h00001000, a = 0, b = 0, program_status_word = 32'h0000005A, rv, pv;
	logic [4:0] fl = 0, fv;
	logic [7:0] wv;
	logic il;
	integer failures = 0, comparisons = 0;
	wire [31:0] rdd, pco, cps, css, madr;
	wire [15:0] mrd;
	wire [7:0] mwd;
	wire [4:0] flo;
	wire dn, rwe, fwe, pwe, mr, mw, sus, ilg;
	lbx_exec_unit lbx_exec_unit_i (.mclk_i, .rst_i, .start_i, .instr_i(ins), .pc_i(pc),
		.rs1_data_i(a), .rs2_data_i(b), .call_table_base_i(32'h00000100), .psw_flags_i(fl),
		.psw_word_i(program_status_word), .mem_rdata_i(mrd), .irq_pending_i(irq), .rs1_addr_o(), .rs2_addr_o(),
		.busy_o(), .done_o(dn), .illegal_o(ilg), .rd_we_o(rwe), .rd_addr_o(), .rd_data_o(rdd),
		.flags_we_o(fwe), .flags_o(flo), .pc_we_o(pwe), .pc_o(pco), .ct_save_we_o(),
		.call_return_pc_save_o(cps), .call_return_status_save_o(css), .mem_rd_o(mr),
		.mem_wr_o(mw), .mem_half_o(), .mem_addr_o(madr), .mem_wdata_o(mwd), .suspended_o(sus));
	lbx_mem_model lbx_mem_model_i (.mclk_i, .mem_rd_i(mr), .mem_wr_i(mw), .mem_addr_i(madr),
		.mem_wdata_i(mwd), .mem_rdata_o(mrd));
	initial forever #12.5 mclk_i = ~mclk_i;
	always @(posedge mclk_i)
	begin
		if (rwe) rv <= rdd;
		if (fwe) fv <= flo;
		if (pwe) pv <= pco;
		if (mw) wv <= mwd;
		if (ilg) il <= 1'b1;
	end
	function logic tk(input [3:0] c, input [4:0] f);
		logic r;
		case (c[2:0])
			3'h0: r = f[2];
			3'h1: r = f[3];
			3'h2: r = f[0];
			3'h3: r = f[3] | f[0];
			3'h4: r = f[1];
			3'h5: r = 1'b1;
			3'h6: r = f[1] ^ f[2];
			default: r = f[1] ^ f[2] | f[0];
		endcase
		return c == 4'hD ? f[4] : r ^ c[3];
	endfunction
	task summarize;
		$display("failures %0d comparisons %0d", failures, comparisons);
		if (failures == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task ck32(input [31:0] g, input [31:0] e);
		comparisons++;
		if (g !== e)
		begin
			failures++;
			$display("FAIL %0t word %h want %h", $time, g, e);
		end
	endtask
	task ck5(input [4:0] g, input [4:0] e);
		comparisons++;
		if (g !== e)
		begin
			failures++;
			$display("FAIL %0t flags %h want %h", $time, g, e);
		end
	endtask
	// results left unknown mean the op never wrote them
	task go(input [31:0] i);
		rv = 'x;
		fv = 'x;
		pv = 'x;
		@(posedge mclk_i);
		start_i <= 1;
		ins <= i;
		@(posedge mclk_i);
		start_i <= 0;
		repeat (20)
		begin
			@(posedge mclk_i);
			if (dn === 1'b1) break;
		end
		ck5({4'h0, dn}, 5'h01);
	endtask
	task op(input [31:0] i, x, y, input [4:0] f, input [31:0] er, input [4:0] ef);
		a <= x;
		b <= y;
		fl <= f;
		go(i);
		ck32(rv, er);
		ck5(fv, ef);
	endtask
	task t_logic;
		op({16'h0000, 16'h1141}, 32'hF0F00000, 32'h0F0FFFFF, 5'h1E, 0, 5'h19);
		op({16'h0000, 16'h1141}, 32'h80000001, 32'hFFFFFFF0, 0, 32'h80000000, 5'h02);
		op({16'h8001, 16'h16C1}, 32'hFFFFFFFF, 0, 5'h1E, 32'h00008001, 5'h1A);
		op({16'hFFFF, 16'h1601}, 32'h5, 0, 0, 32'h4, 5'h08);
	endtask
	task t_swap;
		op({16'h1B42, 16'h17E0}, 0, 32'h12340056, 5'h14, 32'h34125600, 5'h18);
		op({16'h1B42, 16'h17E0}, 0, 32'h56780000, 0, 32'h78560000, 5'h09);
		op({16'h1B40, 16'h17E0}, 0, 32'h00000080, 0, 32'h80000000, 5'h0A);
		op({16'h1B40, 16'h17E0}, 0, 32'h11223344, 5'h0C, 32'h44332211, 0);
	endtask
	task t_br;
		for (int f = 0; f < 32; f += 11)
			for (int c = 0; c < 16; c++)
			begin
				op({16'h0000, 5'h1F, 4'hB, 3'h0, 4'(c)}, 0, 0, 5'(f), 'x, 'x);
				ck32(pv, tk(4'(c), 5'(f)) ? pc - 32'h10 : pc + 32'h2);
			end
		op({16'h0000, 16'h0585}, 0, 0, 0, 'x, 'x);
		ck32(pv, pc);
	endtask
	task t_conditional_move_op;
		for (int c = 0; c < 16; c++)
		begin
			op({5'h03, 6'h19, 4'(c), 1'b0, 16'h17E1}, 32'h11, 32'h22, 5'h0B,
				tk(4'(c), 5'h0B) ? 32'h11 : 32'h22, 'x);
			op({5'h03, 6'h18, 4'(c), 1'b0, 16'h17FE}, 32'h11, 32'h22, 5'h0B,
				tk(4'(c), 5'h0B) ? 32'hFFFFFFFE : 32'h22, 'x);
		end
	endtask
	task t_call(input logic q, input [5:0] m, input [31:0] e);
		irq <= q;
		fork
			op({26'h0000008, m}, 0, 0, 5'h03, 'x, 'x);
			if (q)
			begin
				repeat (6) @(posedge mclk_i);
				ck5({4'h0, sus}, 5'h01);
				irq <= 0;
			end
		join
		ck32(pv, e);
		ck32(cps, pc + 32'h2);
		ck32(css, program_status_word);
	endtask
	task t_clr;
		op({16'hFFF5, 16'h97C1}, 32'h10, 0, 5'h1E, 'x, 5'h1E);
		ck32({24'h0, wv}, 32'h51);
		op({16'hFFF5, 16'h97C1}, 32'h10, 0, 5'h1E, 'x, 5'h1F);
		op({16'h00E4, 16'h17E1}, 32'h9, 32'h7, 5'h01, 'x, 0);
		ck32({24'h0, wv}, 32'h19);
	endtask
	// an undecoded word must pulse illegal and write nothing
	task t_ill;
		il = 1'b0;
		op(32'h00000000, 0, 0, 5'h1F, 'x, 'x);
		ck5({4'h0, il}, 5'h01);
	endtask
	initial
	begin
		#100000;
		failures++;
		summarize();
	end
	initial
	begin
		repeat (2) @(posedge mclk_i);
		rst_i <= 0;
		t_logic();
		t_swap();
		t_br();
		t_conditional_move_op();
		t_call(0, 6'h03, 32'h00007866);
		t_call(1, 6'h05, 32'h0000BCAA);
		t_clr();
		t_ill();
		summarize();
	end
endmodule
